// [dv/acmcs_assertions.sv]
/*
  Checker on the top ports.
  Assumes samples carry their channel code in bits 15:14.
*/
`timescale 1ns/1ns
`default_nettype none
module acmcs_assertions (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wrData,
  input wire logic        wrEn,
  input wire logic        rdEn,
  input wire logic [31:0] rdData_r,
  input wire logic        crystalOscEnable_r,
  input wire logic [1:0]  clkMultiplier_r,
  input wire logic        converterRateClock,
  input wire logic [15:0] convSample_r,
  input wire logic [1:0]  convChan_r,
  input wire logic        convValid_r,
  input wire logic [2:0]  lamp_r
);
  //////////////////////////////////////////
  // Control write with a given crystal bit
  sequence s_xtal_wr(bit v);
    wrEn && addr == acmcs_pkg::REG_CTRL && wrData[2] == v;
  endsequence
  // Control write, pixel-rate input, given mode
  sequence s_pix_wr(logic [1:0] m);
    wrEn && addr == acmcs_pkg::REG_CTRL && wrData[3] && wrData[1:0] == m;
  endsequence
  //////////////////////////////////////////
  a_rd_idle: assert property (@(posedge clk) disable iff (!rstn)
    !$past(rdEn) |-> rdData_r == 32'h0) else $error("read data outside its cycle");
  a_xtal_on: assert property (@(posedge clk) disable iff (!rstn)
    s_xtal_wr(1'b1) |-> ##2 crystalOscEnable_r) else $error("oscillator not enabled");
  a_xtal_off: assert property (@(posedge clk) disable iff (!rstn)
    s_xtal_wr(1'b0) |-> ##2 !crystalOscEnable_r) else $error("oscillator not disabled");
  a_xtal_cause: assert property (@(posedge clk) disable iff (!rstn)
    $changed(crystalOscEnable_r) |-> $past(wrEn, 2)) else $error("oscillator changed alone");
  a_mult_three: assert property (@(posedge clk) disable iff (!rstn)
    s_pix_wr(2'h0) |-> ##2 clkMultiplier_r == 2'h3) else $error("multiplier not three");
  a_mult_two: assert property (@(posedge clk) disable iff (!rstn)
    s_pix_wr(2'h1) |-> ##2 clkMultiplier_r == 2'h2) else $error("multiplier not two");
  a_valid_hold: assert property (@(posedge converterRateClock) disable iff (!rstn)
    convValid_r |=> convValid_r) else $error("valid dropped");
  a_chan_legal: assert property (@(posedge converterRateClock) disable iff (!rstn)
    convValid_r |-> convChan_r != 2'h3) else $error("illegal channel code");
  a_sample_tag: assert property (@(posedge converterRateClock) disable iff (!rstn)
    convValid_r |-> convSample_r[15:14] == convChan_r) else $error("sample from wrong input");
  a_lamp_onehot: assert property (@(posedge converterRateClock) disable iff (!rstn)
    $onehot0(lamp_r)) else $error("lamp not one-hot");
endmodule : acmcs_assertions
bind acmcs_top acmcs_assertions u_chk (.*);
`default_nettype wire

// [dv/acmcs_sensor_model.sv]
/*
  Sensor model: tagged random samples, line sync per lineReq toggle.
  Assumes lineReq from another clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module acmcs_sensor_model (
  input  wire logic        converterRateClock,
  input  wire logic        lineReq,
  output logic             lineSyncPulse,
  output logic             blackPixel,
  output logic      [15:0] blueInput,
  output logic      [15:0] greenInput,
  output logic      [15:0] redInput
);
  logic [2:0] reqSync; // Request synchroniser
  // Quiet start
  initial
  begin
    {reqSync, lineSyncPulse, blackPixel, blueInput, greenInput, redInput} = '0;
  end
  always @(posedge converterRateClock)
  begin
    reqSync <= {reqSync[1:0], lineReq};
    lineSyncPulse <= reqSync[2] ^ reqSync[1];
    blackPixel <= 1'($urandom);
    blueInput <= {acmcs_pkg::CH_BLUE, 14'($urandom)};
    greenInput <= {acmcs_pkg::CH_GREEN, 14'($urandom)};
    redInput <= {acmcs_pkg::CH_RED, 14'($urandom)};
  end
endmodule : acmcs_sensor_model
`default_nettype wire

// [dv/acmcs_top_tb.sv]
/*
  Bench: register driver, queued read notes, slot scoreboard.
  Assumes the sensor model.
*/
`timescale 1ns/1ns
`default_nettype none
module acmcs_top_tb;
  logic        clk, rstn, wrEn, rdEn, convClk, lineReq, rdLate, lsPrev;
  logic        crystalOscEnable_r, convValid_r, lineSyncPulse, blackPixel;
  logic [7:0]  addr;
  logic [31:0] wrData, rdData_r, lastRd;
  logic [1:0]  clkMultiplier_r, convChan_r;
  logic [15:0] blueInput, greenInput, redInput, convSample_r;
  logic [8:0]  offsetCode_r;
  logic [7:0]  gainCode_r;
  logic [2:0]  lamp_r, seen;
  logic [8:0]  ofsV [3];      // Offsets written
  logic [7:0]  gnV [3];       // Gains written
  logic [63:0] rdQ [$];       // Read notes {mask, value}
  logic [1:0]  chQ [$];       // Expected slot channels
  int          n_fail, checks_done, slotCnt;
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    convClk = 1'b0;
    #1;
    forever #3 convClk = ~convClk;
  end
  acmcs_top uut (.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData_r(rdData_r), .clkFormatDiff(1'b1), .crystalOscEnable_r(crystalOscEnable_r),
    .clkMultiplier_r(clkMultiplier_r), .converterRateClock(convClk), .lineSyncPulse(lineSyncPulse),
    .blackPixel(blackPixel), .blueInput(blueInput), .greenInput(greenInput), .redInput(redInput),
    .convSample_r(convSample_r), .convChan_r(convChan_r), .convValid_r(convValid_r),
    .offsetCode_r(offsetCode_r), .gainCode_r(gainCode_r), .lamp_r(lamp_r));
  acmcs_sensor_model u_sens (.converterRateClock(convClk), .lineReq(lineReq),
    .lineSyncPulse(lineSyncPulse), .blackPixel(blackPixel), .blueInput(blueInput),
    .greenInput(greenInput), .redInput(redInput));
  ////////////////////////////////////////
  // Count and report one comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // One-cycle write, gap after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask : wr
  // One-cycle read, expectation noted
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    rdQ.push_back({m, e});
    @(posedge clk);
    rdEn <= 1'b0;
  endtask : rd
  // Poll until config reaches converter side
  task automatic settle();
    for (int k = 0; k < 50; k++)
    begin
      rd(acmcs_pkg::REG_STAT, 32'h0, 32'h0);
      @(posedge clk);
      if (lastRd[4] === 1'b0)
        return;
    end
    cmp(lastRd, 32'h0, "config stuck");
  endtask : settle
  // Configure, start a line, expect six slots
  task automatic line(input logic [31:0] ctrl, input logic [5:0] ord, input logic [11:0] pat);
    wr(acmcs_pkg::REG_ORDER, {26'h0, ord});
    wr(acmcs_pkg::REG_CTRL, ctrl);
    settle();
    for (int k = 0; k < 6; k++)
      chQ.push_back(pat[2*k +: 2]);
    lineReq <= ~lineReq;
    for (int k = 0; k < 200 && chQ.size() != 0; k++)
      @(posedge clk);
    cmp(32'(chQ.size()), 32'h0, "slots missing");
  endtask : line
  ////////////////////////////////////////
  // Read monitor: oldest note per result
  always @(posedge clk)
    rdLate <= rdEn;
  always @(negedge clk)
    if (rdLate && rdQ.size() != 0)
    begin : rdChk
      logic [63:0] e;
      e = rdQ.pop_front();
      lastRd = rdData_r;
      if (e[63:32] != 32'h0)
        cmp(rdData_r & e[63:32], e[31:0], "read");
    end
  // Slot monitor: four edges after line sync
  always @(posedge convClk)
  begin
    lsPrev <= lineSyncPulse;
    if (chQ.size() == 0)
      slotCnt <= 0;
    else if (lineSyncPulse && !lsPrev)
      slotCnt <= 1;
    else if (slotCnt != 0 && slotCnt < 4)
      slotCnt <= slotCnt + 1;
  end
  always @(negedge convClk)
    if (slotCnt == 4 && chQ.size() != 0)
    begin : slotChk
      logic [1:0] c;
      c = chQ.pop_front();
      cmp(32'(convChan_r), 32'(c), "channel");
      cmp(32'(convSample_r[15:14]), 32'(c), "sample source");
      cmp(32'(offsetCode_r), 32'(ofsV[c]), "offset");
      cmp(32'(gainCode_r), 32'(gnV[c]), "gain");
    end
  // Watchdog
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn, wrEn, rdEn, lineReq, rdLate, lsPrev} = 6'h00;
    {addr, wrData, lastRd} = 72'h0;
    {n_fail, checks_done, slotCnt} = 0;
    void'($urandom(32'h2508E640));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(acmcs_pkg::REG_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(acmcs_pkg::REG_ORDER, 32'h24, 32'hFFFFFFFF);
    rd(acmcs_pkg::REG_STAT, 32'h9, 32'hF);
    wr(8'h24, $urandom);
    rd(8'h24, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++)
    begin
      ofsV[i] = 9'($urandom);
      gnV[i] = 8'($urandom);
      wr(8'(acmcs_pkg::REG_OFS_BASE + 4 * i), {23'h0, ofsV[i]});
      wr(8'(acmcs_pkg::REG_GAIN_BASE + 4 * i), {24'h0, gnV[i]});
    end
    for (int i = 0; i < 3; i++)
    begin
      rd(8'(acmcs_pkg::REG_OFS_BASE + 4 * i), {23'h0, ofsV[i]}, 32'hFFFFFFFF);
      rd(8'(acmcs_pkg::REG_GAIN_BASE + 4 * i), {24'h0, gnV[i]}, 32'hFFFFFFFF);
    end
    wr(acmcs_pkg::REG_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    cmp(32'(crystalOscEnable_r), 32'h1, "crystal enable");
    rd(acmcs_pkg::REG_STAT, 32'h5, 32'hF);
    for (int m = 0; m < 3; m++)
    begin
      wr(acmcs_pkg::REG_CTRL, 32'(8 + m));
      rd(acmcs_pkg::REG_STAT, 32'(3 - m), 32'h3);
    end
    line(32'h0, 6'h24, 12'h924);
    line(32'h0, 6'h12, 12'h492);
    line(32'h1, 6'h24, 12'h444);
    line(32'h201, 6'h24, 12'h111);
    for (int s = 0; s < 3; s++)
      line(32'(2 + (s << 7)), 6'h24, {6{2'(s)}});
    for (int c = 1; c < 3; c++)
    begin
      wr(acmcs_pkg::REG_CTRL, 32'(c << 5));
      settle();
      seen = 3'h0;
      repeat (3)
      begin
        lineReq <= ~lineReq;
        repeat (20) @(posedge clk);
        seen = seen | lamp_r;
      end
      cmp(32'(seen), 32'h7, "lamp sequence");
    end
    wr(acmcs_pkg::REG_CTRL, 32'h0);
    settle();
    cmp(32'(lamp_r), 32'h0, "lamp off");
    close_out();
  end
endmodule : acmcs_top_tb
`default_nettype wire

// [rtl/acmcs_pkg.sv]
/*
  Constants shared by the channel mode and clock select block:
  register offsets, field positions, reset values, channel codes,
  sampling rates and the slot counts derived from them.
  Assumes a 32-bit register port with byte addresses, word aligned.
*/
package acmcs_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_ORDER     = 8'h04;
  localparam logic [7:0]  REG_OFS_BASE  = 8'h08;
  localparam logic [7:0]  REG_GAIN_BASE = 8'h14;
  localparam logic [7:0]  REG_STAT      = 8'h20;
  localparam logic [7:0]  REG_STRIDE    = 8'h04;
  // Control field positions
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_XTAL_BIT = 2;
  localparam int          CTRL_PIXIN_BIT = 3;
  localparam int          CTRL_AUTO_BIT = 4;
  localparam int          CTRL_CIS_LSB  = 5;
  localparam int          CTRL_SEL_LSB  = 7;
  localparam int          CTRL_SWAP_BIT = 9;
  localparam int          CTRL_W        = 10;
  // Reset values
  localparam logic [9:0]  CTRL_RST      = 10'h000;
  localparam logic [5:0]  ORDER_RST     = 6'h24;
  localparam logic [8:0]  OFS_RST       = 9'h000;
  localparam logic [7:0]  GAIN_RST      = 8'h00;
  // Mode codes
  localparam logic [1:0]  MODE_3CH      = 2'h0;
  localparam logic [1:0]  MODE_2CH      = 2'h1;
  localparam logic [1:0]  MODE_1CH      = 2'h2;
  // Contact sensor lamp modes
  localparam logic [1:0]  CIS_OFF       = 2'h0;
  localparam logic [1:0]  CIS_A         = 2'h1;
  localparam logic [1:0]  CIS_B         = 2'h2;
  // Channel codes
  localparam logic [1:0]  CH_BLUE       = 2'h0;
  localparam logic [1:0]  CH_GREEN      = 2'h1;
  localparam logic [1:0]  CH_RED        = 2'h2;
  // Sampling rates in kilo-samples per second
  localparam int          CONV_RATE_KSPS = 45000;
  localparam int          PIX3_RATE_KSPS = 15000;
  localparam int          PIX2_RATE_KSPS = 22500;
  // Converter slots per pixel and internal clock multipliers
  localparam logic [1:0]  SLOTS_3CH     = 2'(CONV_RATE_KSPS / PIX3_RATE_KSPS);
  localparam logic [1:0]  SLOTS_2CH     = 2'(CONV_RATE_KSPS / PIX2_RATE_KSPS);
  localparam logic [1:0]  SLOTS_1CH     = 2'h1;
  // Black level loop target and offset limits
  localparam logic [15:0] BLACK_TARGET  = 16'h0100;
  localparam logic [8:0]  OFS_MAX       = 9'h0FF;
  localparam logic [8:0]  OFS_MIN       = 9'h100;
endpackage : acmcs_pkg

// [rtl/acmcs_slot_seq.sv]
/*
  Converter slot sequencer: picks the input channel for each converter
  slot of a pixel. Runs on the converter rate clock; mode and order
  come from shadow registers already in that domain.
*/
`timescale 1ns/1ns
`default_nettype none
module acmcs_slot_seq (
  input  wire logic       converterRateClock, // Converter rate clock
  input  wire logic       rstn,               // Async reset, active low
  input  wire logic       lineStart,          // One-cycle line start
  input  wire logic [1:0] mode,               // Channel mode
  input  wire logic [5:0] order,              // Three-channel order
  input  wire logic [1:0] singleSel,          // One-channel input
  input  wire logic       swapEvenOdd,        // Two-channel swap
  output logic      [1:0] slotChan_r,         // Channel of this slot
  output logic            pixelDone_r         // High the cycle after the pixel's last slot
);
  logic [1:0] slotCnt_r;  // Slot within pixel
  logic [1:0] slotCnt_nxt;
  logic [1:0] slots;      // Slots per pixel
  logic       lastSlot;

  // Channel of a slot for the current mode
  function automatic logic [1:0] chanOf(input logic [1:0] slot);
    logic [1:0] ch;
    ch = singleSel;
    if (mode == acmcs_pkg::MODE_3CH)
    begin
      ch = order[2 * slot +: 2];
    end
    else if (mode == acmcs_pkg::MODE_2CH)
    begin
      // Even pixel on slot 0, odd on slot 1
      ch = ((slot == 2'h0) ^ swapEvenOdd) ? acmcs_pkg::CH_BLUE : acmcs_pkg::CH_GREEN;
    end
    return ch;
  endfunction : chanOf

  assign slots = (mode == acmcs_pkg::MODE_3CH) ? acmcs_pkg::SLOTS_3CH :
                 (mode == acmcs_pkg::MODE_2CH) ? acmcs_pkg::SLOTS_2CH : acmcs_pkg::SLOTS_1CH;
  assign lastSlot = (slotCnt_r >= slots - 2'h1);
  assign slotCnt_nxt = (lineStart || lastSlot) ? 2'h0 : slotCnt_r + 2'h1;

  ////////////////////////////////////////////////////////////////////////
  // Slot counter and channel register
  always_ff @(posedge converterRateClock or negedge rstn)
  begin
    if (!rstn)
    begin
      slotCnt_r   <= 2'h0;
      slotChan_r  <= acmcs_pkg::CH_BLUE;
      pixelDone_r <= 1'b0;
    end
    else
    begin
      slotCnt_r   <= slotCnt_nxt;
      slotChan_r  <= chanOf(slotCnt_nxt);
      pixelDone_r <= lastSlot && !lineStart;
    end
  end
endmodule : acmcs_slot_seq
`default_nettype wire

// [rtl/acmcs_top.sv]
/*
  Channel mode and clock select control for a three-input imaging
  front end: register port, clock source and multiplier selection,
  converter slot ordering, per-channel offset and gain, black level
  loop and contact sensor lamp sequencing.
  Assumes clk is the register port clock and converterRateClock an
  unrelated clock from the clock path; pins are asynchronous.
*/
// Decided for this implementation: the plain strobed port and the register addresses.
// Behaviour
// - Three-channel order programmable, restarts per line
// - Three inputs share one converter, three slots
// - Two-channel default: even blue, odd green
// - Two-channel: two converter slots per pixel
// - One-channel input chosen by control register
// - Contact sensor modes sequence lamp and coefficients
// - Crystal bit clear: external clock, format sensed
// - Crystal bit set: on-chip oscillator driver
// - Per-channel signed offset and gain registers
// - Manual or automatic black level offset
// - Clock multiplier three, two or one
`timescale 1ns/1ns
`default_nettype none
module acmcs_top (
  input  wire logic        clk,                // Register clock
  input  wire logic        rstn,               // Async reset, active low
  input  wire logic [7:0]  addr,               // Register byte address
  input  wire logic [31:0] wrData,             // Write data
  input  wire logic        wrEn,               // Write strobe
  input  wire logic        rdEn,               // Read strobe
  output logic      [31:0] rdData_r,           // Read data, next cycle
  input  wire logic        clkFormatDiff,      // Sensed clock format pin
  output logic             crystalOscEnable_r, // Oscillator driver on
  output logic      [1:0]  clkMultiplier_r,    // Internal multiplier
  input  wire logic        converterRateClock, // Converter clock
  input  wire logic        lineSyncPulse,      // Line sync pin
  input  wire logic        blackPixel,         // Optical black pin
  input  wire logic [15:0] blueInput,          // Blue sampled code
  input  wire logic [15:0] greenInput,         // Green sampled code
  input  wire logic [15:0] redInput,           // Red sampled code
  output logic      [15:0] convSample_r,       // Sample to converter
  output logic      [1:0]  convChan_r,         // Channel of sample
  output logic             convValid_r,        // Sample valid
  output logic      [8:0]  offsetCode_r,       // Offset for this slot
  output logic      [7:0]  gainCode_r,         // Gain for this slot
  output logic      [2:0]  lamp_r              // Lamp drive, one-hot, zero when lamps off
);
  localparam int CFG_W = acmcs_pkg::CTRL_W + 6 + 27 + 24;

  ////////////////////////////////////////////////////////////////////////
  // Register port side (clk)
  logic [9:0]       ctrl_r;        // Control register
  logic [5:0]       order_r;       // Slot order register
  logic [8:0]       ofs_r [0:2];   // Offset per channel
  logic [7:0]       gain_r [0:2];  // Gain per channel
  logic [2:0]       ofsHit;        // Offset write decode
  logic [2:0]       gainHit;       // Gain write decode
  logic             ctrlHit;
  logic             orderHit;
  logic [26:0]      ofsVec;        // Offsets packed
  logic [23:0]      gainVec;       // Gains packed
  logic [CFG_W-1:0] cfgVec;        // Whole configuration
  logic [CFG_W-1:0] snap_r;        // Held copy for crossing
  logic             cfgPend_r;     // Config changed, not sent
  logic             cfgTgl_r;      // Config request toggle
  logic             cfgAck1_r;     // Ack synchroniser
  logic             cfgAck2_r;
  logic             cvCfg3_r;
  logic             cfgBusy;
  logic             cfgSend;
  logic             fmt1_r;        // Clock format synchroniser
  logic             fmt2_r;
  logic             res1_r;        // Result toggle synchroniser
  logic             res2_r;
  logic             res3_r;
  logic             resNew;
  logic [26:0]      resOfs_r;      // Black loop result, conv side
  logic [1:0]       multNxt;
  logic [31:0]      rdMux;
  logic [1:0]       ctrlMode;

  // Write decode
  assign ctrlHit  = wrEn && (addr == acmcs_pkg::REG_CTRL);
  assign orderHit = wrEn && (addr == acmcs_pkg::REG_ORDER);
  assign ctrlMode = ctrl_r[acmcs_pkg::CTRL_MODE_LSB +: 2];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_chan
      assign ofsHit[gi]  = wrEn && (addr == acmcs_pkg::REG_OFS_BASE + 8'(gi * 4));
      assign gainHit[gi] = wrEn && (addr == acmcs_pkg::REG_GAIN_BASE + 8'(gi * 4));
      assign ofsVec[9*gi +: 9]  = ofs_r[gi];
      assign gainVec[8*gi +: 8] = gain_r[gi];
      // Software write wins over a loop result in the same cycle
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          ofs_r[gi]  <= acmcs_pkg::OFS_RST;
          gain_r[gi] <= acmcs_pkg::GAIN_RST;
        end
        else
        begin
          if (ofsHit[gi])
          begin
            ofs_r[gi] <= wrData[8:0];
          end
          else if (resNew && ctrl_r[acmcs_pkg::CTRL_AUTO_BIT])
          begin
            ofs_r[gi] <= resOfs_r[9*gi +: 9];
          end
          if (gainHit[gi])
          begin
            gain_r[gi] <= wrData[7:0];
          end
        end
      end
    end
  endgenerate

  // Control and order registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r  <= acmcs_pkg::CTRL_RST;
      order_r <= acmcs_pkg::ORDER_RST;
    end
    else
    begin
      if (ctrlHit)
      begin
        ctrl_r <= wrData[9:0];
      end
      if (orderHit)
      begin
        order_r <= wrData[5:0];
      end
    end
  end

  // multiplier from mode and input rate
  assign multNxt = !ctrl_r[acmcs_pkg::CTRL_PIXIN_BIT] ? 2'h1 :
                   (ctrlMode == acmcs_pkg::MODE_3CH) ? acmcs_pkg::SLOTS_3CH :
                   (ctrlMode == acmcs_pkg::MODE_2CH) ? acmcs_pkg::SLOTS_2CH : 2'h1;

  // Read decode
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (addr == acmcs_pkg::REG_CTRL)
    begin
      rdMux[9:0] = ctrl_r;
    end
    else if (addr == acmcs_pkg::REG_ORDER)
    begin
      rdMux[5:0] = order_r;
    end
    else if (addr == acmcs_pkg::REG_STAT)
    begin
      rdMux[4:0] = {cfgPend_r | cfgBusy, fmt2_r, crystalOscEnable_r, clkMultiplier_r};
    end
    for (int i = 0; i < 3; i++)
    begin
      if (addr == acmcs_pkg::REG_OFS_BASE + 8'(i * 4))
      begin
        rdMux[8:0] = ofs_r[i];
      end
      else if (addr == acmcs_pkg::REG_GAIN_BASE + 8'(i * 4))
      begin
        rdMux[7:0] = gain_r[i];
      end
    end
  end

  // Read data, clock outputs and format synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdData_r           <= 32'h0000_0000;
      crystalOscEnable_r <= 1'b0;
      clkMultiplier_r    <= 2'h1;
      fmt1_r             <= 1'b0;
      fmt2_r             <= 1'b0;
    end
    else
    begin
      rdData_r           <= rdEn ? rdMux : 32'h0000_0000;
      crystalOscEnable_r <= ctrl_r[acmcs_pkg::CTRL_XTAL_BIT];
      clkMultiplier_r    <= multNxt;
      // sensed format, only with external clock
      fmt1_r             <= clkFormatDiff;
      fmt2_r             <= fmt1_r & ~crystalOscEnable_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration crossing: toggle handshake with held copy
  assign cfgVec  = {gainVec, ofsVec, order_r, ctrl_r};
  assign cfgBusy = cfgTgl_r ^ cfgAck2_r;
  assign cfgSend = cfgPend_r && !cfgBusy;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfgPend_r <= 1'b1;
      cfgTgl_r  <= 1'b0;
      snap_r    <= '0;
      cfgAck1_r <= 1'b0;
      cfgAck2_r <= 1'b0;
    end
    else
    begin
      // A write in the send cycle keeps the change pending
      cfgPend_r <= wrEn || resNew || (cfgPend_r && !cfgSend);
      if (cfgSend)
      begin
        snap_r   <= cfgVec;
        cfgTgl_r <= ~cfgTgl_r;
      end
      cfgAck1_r <= cvCfg3_r;
      cfgAck2_r <= cfgAck1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter side (converterRateClock)
  logic        cvCfg1_r;     // Config toggle synchroniser
  logic        cvCfg2_r;
  logic        ls1_r;        // Line sync synchroniser
  logic        ls2_r;
  logic        ls3_r;
  logic        bk1_r;        // Black pixel synchroniser
  logic        bk2_r;
  logic        bk3_r;
  logic        resTgl_r;     // Result toggle
  logic        resAck1_r;
  logic        resAck2_r;
  logic [CFG_W-1:0] sh_r;    // Shadow configuration
  logic [8:0]  ofsAct_r [0:2]; // Offsets in use
  logic [1:0]  lampCh_r;     // Lit colour
  logic        lineSeen_r;   // A line has started
  logic        lineStart;
  logic        blkEnd;
  logic        cfgTake;
  logic [1:0]  slotChan;
  logic [1:0]  coefIdx;
  logic [1:0]  shCis;
  logic [1:0]  lampNxt;
  logic [15:0] selSample;
  logic        autoOn;

  assign lineStart = ls2_r & ~ls3_r;
  assign blkEnd    = ~bk2_r & bk3_r;
  assign cfgTake   = cvCfg2_r ^ cvCfg3_r;
  assign shCis     = sh_r[acmcs_pkg::CTRL_CIS_LSB +: 2];
  assign autoOn    = sh_r[acmcs_pkg::CTRL_AUTO_BIT];

  acmcs_slot_seq u_seq (
    .converterRateClock (converterRateClock),
    .rstn               (rstn),
    .lineStart          (lineStart),
    .mode               (sh_r[acmcs_pkg::CTRL_MODE_LSB +: 2]),
    .order              (sh_r[acmcs_pkg::CTRL_W +: 6]),
    .singleSel          (sh_r[acmcs_pkg::CTRL_SEL_LSB +: 2]),
    .swapEvenOdd        (sh_r[acmcs_pkg::CTRL_SWAP_BIT]),
    .slotChan_r         (slotChan),
    .pixelDone_r        ()
  );

  // Input mux by slot channel
  assign selSample = (slotChan == acmcs_pkg::CH_BLUE)  ? blueInput :
                     (slotChan == acmcs_pkg::CH_GREEN) ? greenInput : redInput;
  assign coefIdx = (shCis == acmcs_pkg::CIS_OFF) ? slotChan : lampCh_r;
  assign lampNxt = (shCis == acmcs_pkg::CIS_A) ?
                   ((lampCh_r == acmcs_pkg::CH_BLUE) ? acmcs_pkg::CH_RED : lampCh_r - 2'h1) :
                   ((lampCh_r == acmcs_pkg::CH_RED) ? acmcs_pkg::CH_BLUE : lampCh_r + 2'h1);

  // Synchronisers, shadow capture and result handshake
  always_ff @(posedge converterRateClock or negedge rstn)
  begin
    if (!rstn)
    begin
      {cvCfg1_r, cvCfg2_r, cvCfg3_r} <= 3'h0;
      {ls1_r, ls2_r, ls3_r}          <= 3'h0;
      {bk1_r, bk2_r, bk3_r}          <= 3'h0;
      {resAck1_r, resAck2_r}         <= 2'h0;
      sh_r     <= '0;
      resTgl_r <= 1'b0;
      resOfs_r <= '0;
    end
    else
    begin
      cvCfg1_r  <= cfgTgl_r;
      cvCfg2_r  <= cvCfg1_r;
      cvCfg3_r  <= cvCfg2_r;
      ls1_r     <= lineSyncPulse;
      ls2_r     <= ls1_r;
      ls3_r     <= ls2_r;
      bk1_r     <= blackPixel;
      bk2_r     <= bk1_r;
      bk3_r     <= bk2_r;
      resAck1_r <= res3_r;
      resAck2_r <= resAck1_r;
      if (cfgTake)
      begin
        sh_r <= snap_r;
      end
      // hand result over after black pixels
      if (blkEnd && autoOn && (resTgl_r == resAck2_r))
      begin
        resOfs_r <= {ofsAct_r[2], ofsAct_r[1], ofsAct_r[0]};
        resTgl_r <= ~resTgl_r;
      end
    end
  end

  // Result toggle into the register clock
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {res1_r, res2_r, res3_r} <= 3'h0;
    end
    else
    begin
      res1_r <= resTgl_r;
      res2_r <= res1_r;
      res3_r <= res2_r;
    end
  end
  assign resNew = res2_r ^ res3_r;

  // Offsets in use: manual copy or black level loop
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_loop
      logic hitCh;
      assign hitCh = bk2_r && convValid_r && (convChan_r == 2'(gi));
      always_ff @(posedge converterRateClock or negedge rstn)
      begin
        if (!rstn)
        begin
          ofsAct_r[gi] <= acmcs_pkg::OFS_RST;
        end
        else if (cfgTake)
        begin
          ofsAct_r[gi] <= snap_r[acmcs_pkg::CTRL_W + 6 + 9*gi +: 9];
        end
        else if (autoOn && hitCh)
        begin
          if (convSample_r > acmcs_pkg::BLACK_TARGET && ofsAct_r[gi] != acmcs_pkg::OFS_MIN)
          begin
            ofsAct_r[gi] <= ofsAct_r[gi] - 9'h001;
          end
          else if (convSample_r < acmcs_pkg::BLACK_TARGET && ofsAct_r[gi] != acmcs_pkg::OFS_MAX)
          begin
            ofsAct_r[gi] <= ofsAct_r[gi] + 9'h001;
          end
        end
      end
    end
  endgenerate

  // Converter outputs and lamp sequence
  always_ff @(posedge converterRateClock or negedge rstn)
  begin
    if (!rstn)
    begin
      convSample_r <= 16'h0000;
      convChan_r   <= acmcs_pkg::CH_BLUE;
      convValid_r  <= 1'b0;
      offsetCode_r <= acmcs_pkg::OFS_RST;
      gainCode_r   <= acmcs_pkg::GAIN_RST;
      lamp_r       <= 3'h0;
      lampCh_r     <= acmcs_pkg::CH_RED;
      lineSeen_r   <= 1'b0;
    end
    else
    begin
      convSample_r <= selSample;
      convChan_r   <= slotChan;
      convValid_r  <= lineSeen_r;
      lineSeen_r   <= lineSeen_r | lineStart;
      offsetCode_r <= ofsAct_r[coefIdx];
      gainCode_r   <= sh_r[acmcs_pkg::CTRL_W + 6 + 27 + 8*coefIdx +: 8];
      if (shCis == acmcs_pkg::CIS_OFF)
      begin
        lampCh_r <= acmcs_pkg::CH_RED;
      end
      else if (lineStart)
      begin
        lampCh_r <= lampNxt;
      end
      lamp_r <= (shCis == acmcs_pkg::CIS_OFF) ? 3'h0 : 3'(3'h1 << lampCh_r);
    end
  end
endmodule : acmcs_top
`default_nettype wire
